// file: das_pkg.sv
// Shared constants of the dual converter output sequencer.
package das_pkg;
   // Result width and the signed full-scale limits of one channel word.
   localparam int DATA_W = 10;
   localparam int IN_W   = 12;
   localparam int FS_POS = 511;
   localparam int FS_NEG = -512;

   ////////////////////////////////////////////////////////////////////////////
   // System clock and the derived output delay.
   localparam int SYS_PERIOD_PS        = 4000;
   localparam int SYS_CLK_MHZ          = 250;
   localparam int OUTPUT_DELAY_TIME_NS = 8;
   // A least time, so it rounds up to whole cycles.
   localparam int OUT_DLY_CYC =
      (OUTPUT_DELAY_TIME_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;

   // Highest conversion rate and the shortest converter clock period it implies.
   localparam int MAX_RATE_MSPS       = 30;
   localparam int MIN_CONV_PERIOD_CYC =
      (SYS_CLK_MHZ + MAX_RATE_MSPS - 1) / MAX_RATE_MSPS;

   ////////////////////////////////////////////////////////////////////////////
   // Offset trim sequence: conversions in total, averaged count, and the shift.
   localparam int TRIM_CYCLES = 34;
   localparam int TRIM_AVG    = 32;
   localparam int TRIM_SHIFT  = 5;
   localparam int TRIM_SETTLE = TRIM_CYCLES - TRIM_AVG;
   localparam int TRIM_CNT_W  = 6;

   ////////////////////////////////////////////////////////////////////////////
   // Bit positions of the control pins inside the synchroniser vector.
   localparam int CB_CLK  = 0;
   localparam int CB_BUS  = 1;
   localparam int CB_FMT  = 2;
   localparam int CB_SLP  = 3;
   localparam int CB_HOLD = 4;
   localparam int CB_TRIM = 5;
   localparam int SYNC_W  = 6;

   // Reset value of every data word.
   localparam logic [DATA_W-1:0] WORD_RST = 10'h000;
endpackage

// file: das_chan.sv
// One converter channel: saturation, offset trim and the sampled word.
`timescale 1ns/100ps
module das_chan #(
   parameter int IN_W = das_pkg::IN_W
) (
   // Clock and reset.
   input  wire logic                             sys_clk_in,
   input  wire logic                             rstn_in,
   // Sample strobe, trim start pulse and the raw input value.
   input  wire logic                             sample_stb_in,
   input  wire logic                             trim_start_in,
   input  wire logic signed [IN_W-1:0]           raw_in,
   // Corrected word and trim status.
   output logic signed [das_pkg::DATA_W-1:0]     word_out,
   output logic                                  trim_busy_out
);
   localparam int DW    = das_pkg::DATA_W;
   localparam int ACC_W = DW + das_pkg::TRIM_SHIFT;
   localparam logic signed [IN_W-1:0] MAXV = IN_W'(das_pkg::FS_POS);
   localparam logic signed [IN_W-1:0] MINV = IN_W'(das_pkg::FS_NEG);
   localparam logic [das_pkg::TRIM_CNT_W-1:0] LAST =
      das_pkg::TRIM_CNT_W'(das_pkg::TRIM_CYCLES - 1);
   localparam logic [das_pkg::TRIM_CNT_W-1:0] SETTLE = das_pkg::TRIM_CNT_W'(das_pkg::TRIM_SETTLE);

   // The raw value must at least hold a full word.
   if (IN_W < DW) begin : g_bad_width
      $error("das_chan: IN_W below the word width");
   end

   logic signed [DW-1:0]    sat;       // Input clamped to full scale.
   logic signed [DW:0]      diff;      // Sample minus offset coefficient.
   logic signed [DW-1:0]    corr;      // Corrected and clamped word.
   logic signed [ACC_W-1:0] nxt_acc;   // Running sum including this sample.
   logic signed [ACC_W-1:0] acc_ff;    // Trim accumulator.
   logic signed [DW-1:0]    coef_ff;   // Offset coefficient, zero after reset.
   logic [das_pkg::TRIM_CNT_W-1:0] cnt_ff;  // Conversions seen in this trim run.
   logic signed [DW-1:0]    word_ff;   // Word of the latest sample.
   logic                    busy_ff;   // Trim run in progress.

   // Over-range inputs stick at the matching full-scale code.
   always_comb begin
      if (raw_in > MAXV) begin
         sat = DW'(das_pkg::FS_POS);
      end else if (raw_in < MINV) begin
         sat = DW'(das_pkg::FS_NEG);
      end else begin
         sat = raw_in[DW-1:0];
      end
   end

   // Subtracting the offset can push the word past full scale, so clamp the difference again.
   always_comb begin
      diff    = {sat[DW-1], sat} - {coef_ff[DW-1], coef_ff};
      nxt_acc = acc_ff + {{das_pkg::TRIM_SHIFT{sat[DW-1]}}, sat};
      if (diff > (DW+1)'(das_pkg::FS_POS)) begin
         corr = DW'(das_pkg::FS_POS);
      end else if (diff < (DW+1)'(das_pkg::FS_NEG)) begin
         corr = DW'(das_pkg::FS_NEG);
      end else begin
         corr = diff[DW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trim sequencer: skip the settling conversions, then sum the average count.
   // A start while a run is busy is ignored, so a bouncing pin cannot restart it.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         busy_ff <= 1'b0;
         cnt_ff  <= '0;
         acc_ff  <= '0;
      end else if (!busy_ff && trim_start_in) begin
         busy_ff <= 1'b1;
         cnt_ff  <= '0;
         acc_ff  <= '0;
      end else if (busy_ff && sample_stb_in) begin
         if (cnt_ff >= SETTLE) begin
            acc_ff <= nxt_acc;
         end
         if (cnt_ff == LAST) begin
            busy_ff <= 1'b0;
         end
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // The coefficient is the sum divided by the average count.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         coef_ff <= '0;
      end else if (busy_ff && sample_stb_in && cnt_ff == LAST) begin
         coef_ff <= DW'(nxt_acc >>> das_pkg::TRIM_SHIFT);
      end
   end

   // The word only moves on a sample strobe and holds otherwise.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         word_ff <= '0;
      end else if (sample_stb_in) begin
         word_ff <= corr;
      end
   end

   assign word_out      = word_ff;
   assign trim_busy_out = busy_ff;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);

   a_word_on_strobe: assert property (
      !$past(sample_stb_in) |-> $stable(word_ff))
      else $error("word changed without a sample strobe");
   a_neg_sat: assert property (
      sample_stb_in && raw_in < MINV && coef_ff == 0 |=> word_ff == DW'(das_pkg::FS_NEG))
      else $error("under-range input did not give negative full scale");
   a_pos_sat: assert property (
      sample_stb_in && raw_in > MAXV && coef_ff == 0 |=> word_ff == DW'(das_pkg::FS_POS))
      else $error("over-range input did not give positive full scale");
   a_trim_end: assert property (
      $fell(busy_ff) |-> $past(cnt_ff) == LAST && $past(sample_stb_in))
      else $error("trim run ended at the wrong conversion count");
   c_trim_done: cover property ($fell(busy_ff));
endmodule

// file: das_seq.sv
// Output sequencer of a dual ten-bit converter: sampling, pipeline, output buses.
//
// Contract
// - Both channels sampled together on falling edge.
// - Parallel mode: each channel on own bus.
// - Parallel words valid output delay after rise.
// - Mux: first after rise, second after fall.
// - Parallel latency two and a half cycles.
// - Mux latency 2.5 first, 3 second.
// - Convert every cycle while awake.
// - Under-range saturates at negative full scale; with a negative offset coefficient the code gives -512 minus it.
// - Over-range saturates at positive full scale; with a positive offset coefficient the code gives 511 minus it.
// - Ten-bit result per sample, up to rate.
// - Bus select high parallel, low multiplexed.
// - Format low offset binary, high twos complement.
// - Sleep or standby holds the last words.
// - Trim edge averages 32 conversions, subtracts.
`timescale 1ns/100ps
module das_seq #(
   parameter int IN_W        = das_pkg::IN_W,
   parameter int OUT_DLY_CYC = das_pkg::OUT_DLY_CYC
) (
   // Clock and reset.
   input  wire logic                          sys_clk_in,
   input  wire logic                          rstn_in,
   // Converter clock pin and the two sampled channel values.
   input  wire logic                          conv_clk_in,
   input  wire logic signed [IN_W-1:0]        chan_i_in,
   input  wire logic signed [IN_W-1:0]        chan_q_in,
   // Control pins.
   input  wire logic                          bus_select_pin_in,
   input  wire logic                          format_select_pin_in,
   input  wire logic                          sleep_pin_in,
   input  wire logic                          low_power_hold_pin_in,
   input  wire logic                          offset_trim_pin_in,
   // Output buses, delayed channel select and trim status.
   output logic [das_pkg::DATA_W-1:0]         bus_i_out,
   output logic [das_pkg::DATA_W-1:0]         bus_q_out,
   output logic                               iq_sel_out,
   output logic                               trim_busy_out
);
   localparam int DW  = das_pkg::DATA_W;
   localparam int ODA = OUT_DLY_CYC + 1;

   // The delayed word must land well inside half of the fastest converter clock.
   if (OUT_DLY_CYC < 1 || OUT_DLY_CYC >= das_pkg::MIN_CONV_PERIOD_CYC / 2) begin : g_bad_dly
      $error("das_seq: OUT_DLY_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers. Every pin passes two flops; the third flop only feeds edge detection.
   logic [das_pkg::SYNC_W-1:0] ctl_s1_ff;   // First stage of the control pins.
   logic [das_pkg::SYNC_W-1:0] ctl_s2_ff;   // Settled control pins.
   logic                       clk_s3_ff;   // Converter clock one cycle older.
   logic                       trim_s3_ff;  // Trim pin one cycle older.
   logic signed [IN_W-1:0]     di_s1_ff;    // First stage of channel one.
   logic signed [IN_W-1:0]     di_s2_ff;    // Settled channel one.
   logic signed [IN_W-1:0]     dq_s1_ff;    // First stage of channel two.
   logic signed [IN_W-1:0]     dq_s2_ff;    // Settled channel two.

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctl_s1_ff  <= '0;
         ctl_s2_ff  <= '0;
         clk_s3_ff  <= 1'b0;
         trim_s3_ff <= 1'b0;
         di_s1_ff   <= '0;
         di_s2_ff   <= '0;
         dq_s1_ff   <= '0;
         dq_s2_ff   <= '0;
      end else begin
         ctl_s1_ff  <= {offset_trim_pin_in, low_power_hold_pin_in, sleep_pin_in,
                        format_select_pin_in, bus_select_pin_in, conv_clk_in};
         ctl_s2_ff  <= ctl_s1_ff;
         clk_s3_ff  <= ctl_s2_ff[das_pkg::CB_CLK];
         trim_s3_ff <= ctl_s2_ff[das_pkg::CB_TRIM];
         di_s1_ff   <= chan_i_in;
         di_s2_ff   <= di_s1_ff;
         dq_s1_ff   <= chan_q_in;
         dq_s2_ff   <= dq_s1_ff;
      end
   end

   logic rise_ev;     // Converter clock rose.
   logic fall_ev;     // Converter clock fell.
   logic awake;       // Neither sleep nor standby.
   logic bus_par;     // Parallel bus mode selected.
   logic fmt_twos;    // Twos complement coding selected.
   logic sample_stb;  // Take a new sample pair.
   logic trim_start;  // Trim pin rose.

   assign rise_ev    = ctl_s2_ff[das_pkg::CB_CLK] && !clk_s3_ff;
   assign fall_ev    = !ctl_s2_ff[das_pkg::CB_CLK] && clk_s3_ff;
   assign awake      = !ctl_s2_ff[das_pkg::CB_SLP] && !ctl_s2_ff[das_pkg::CB_HOLD];
   assign bus_par    = ctl_s2_ff[das_pkg::CB_BUS];
   assign fmt_twos   = ctl_s2_ff[das_pkg::CB_FMT];
   assign sample_stb = fall_ev && awake;
   assign trim_start = ctl_s2_ff[das_pkg::CB_TRIM] && !trim_s3_ff;

   // Offset binary is twos complement with the top bit inverted.
   function automatic logic [DW-1:0] fmt_word(input logic [DW-1:0] w, input logic twos);
      return twos ? w : {~w[DW-1], w[DW-2:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Both channels share one strobe, so their samples are always a pair.
   logic signed [DW-1:0] word_i;  // Sampled word of channel one.
   logic signed [DW-1:0] word_q;  // Sampled word of channel two.
   logic                 busy_i;  // Trim busy, channel one.
   logic                 busy_q;  // Trim busy, channel two.

   das_chan #(.IN_W(IN_W)) u_chan_i (
      .sys_clk_in    (sys_clk_in),
      .rstn_in       (rstn_in),
      .sample_stb_in (sample_stb),
      .trim_start_in (trim_start),
      .raw_in        (di_s2_ff),
      .word_out      (word_i),
      .trim_busy_out (busy_i)
   );

   das_chan #(.IN_W(IN_W)) u_chan_q (
      .sys_clk_in    (sys_clk_in),
      .rstn_in       (rstn_in),
      .sample_stb_in (sample_stb),
      .trim_start_in (trim_start),
      .raw_in        (dq_s2_ff),
      .word_out      (word_q),
      .trim_busy_out (busy_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pipeline moved on falling edges. A fall while asleep flushes the valid bits,
   // so fresh words only return after three awake falls.
   logic [DW-1:0] p1_i_ff, p1_q_ff;       // Second stage words.
   logic [DW-1:0] p2_i_ff, p2_q_ff;       // Third stage words, ready to drive.
   logic          v0_ff, v1_ff, v2_ff;    // Stage valid flags.
   logic [1:0]    awake_cnt_ff;           // Awake falls since the last flush.

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {p1_i_ff, p1_q_ff, p2_i_ff, p2_q_ff} <= '0;
         {v0_ff, v1_ff, v2_ff} <= 3'h0;
      end else if (fall_ev && awake) begin
         p1_i_ff <= word_i;
         p1_q_ff <= word_q;
         p2_i_ff <= p1_i_ff;
         p2_q_ff <= p1_q_ff;
         {v2_ff, v1_ff, v0_ff} <= {v1_ff, v0_ff, 1'b1};
      end else if (fall_ev) begin
         {v0_ff, v1_ff, v2_ff} <= 3'h0;
      end
   end

   // Helper count for checking the refill after a flush.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         awake_cnt_ff <= 2'h0;
      end else if (fall_ev && !awake) begin
         awake_cnt_ff <= 2'h0;
      end else if (fall_ev && awake_cnt_ff != 2'h3) begin
         awake_cnt_ff <= awake_cnt_ff + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge events are held in delay lines for the output delay; the words are
   // captured at the edge itself because the pipeline may shift meanwhile.
   logic [OUT_DLY_CYC-1:0] rdly_ff, fdly_ff;  // Delayed rise and fall events.
   logic [OUT_DLY_CYC:0]   rcat, fcat;        // Shift inputs of the delay lines.
   logic [DW-1:0] hi_ff, hq_ff, mq_ff;        // Words held for the delayed update.
   logic          hv_ff, mv_ff;               // Held words are valid.

   assign rcat = {rdly_ff, rise_ev};
   assign fcat = {fdly_ff, fall_ev};

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdly_ff <= '0;
         fdly_ff <= '0;
         {hi_ff, hq_ff, mq_ff} <= '0;
         {hv_ff, mv_ff} <= 2'h0;
      end else begin
         rdly_ff <= rcat[OUT_DLY_CYC-1:0];
         fdly_ff <= fcat[OUT_DLY_CYC-1:0];
         if (rise_ev) begin
            hi_ff <= p2_i_ff;
            hq_ff <= p2_q_ff;
            hv_ff <= v2_ff;
         end
         if (fall_ev) begin
            mq_ff <= p2_q_ff;
            mv_ff <= v2_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output buses. Without valid held words only the second bus moves, cleared in multiplexed mode, so a sleeping
   // converter keeps showing its last result.
   logic [DW-1:0] bus_i_ff, bus_q_ff;  // Driven bus words.
   logic          iq_sel_ff;           // High from the delayed rise update to the delayed fall update, in both bus modes.

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bus_i_ff  <= das_pkg::WORD_RST;
         bus_q_ff  <= das_pkg::WORD_RST;
         iq_sel_ff <= 1'b0;
      end else begin
         if (rdly_ff[OUT_DLY_CYC-1] && hv_ff) begin
            bus_i_ff  <= fmt_word(hi_ff, fmt_twos);
            bus_q_ff  <= fmt_word(hq_ff, fmt_twos);
            iq_sel_ff <= 1'b1;
         end else if (fdly_ff[OUT_DLY_CYC-1] && mv_ff) begin
            if (!bus_par) begin
               bus_i_ff <= fmt_word(mq_ff, fmt_twos);
            end
            iq_sel_ff <= 1'b0;
         end
         if (!bus_par) begin
            bus_q_ff <= das_pkg::WORD_RST;
         end
      end
   end

   assign bus_i_out     = bus_i_ff;
   assign bus_q_out     = bus_q_ff;
   assign iq_sel_out    = iq_sel_ff;
   assign trim_busy_out = busy_i || busy_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);

   a_par_sel_rise: assert property (
      rise_ev && v2_ff |-> ##ODA iq_sel_ff)
      else $error("select not high one output delay after rise");
   a_par_q_word: assert property (
      rise_ev && v2_ff && bus_par |-> ##ODA
         bus_q_ff == fmt_word($past(p2_q_ff, ODA), $past(fmt_twos)))
      else $error("second bus does not carry its own channel");
   a_mux_q_word: assert property (
      fall_ev && v2_ff && !bus_par |-> ##ODA
         (!iq_sel_ff && bus_i_ff == fmt_word($past(p2_q_ff, ODA), $past(fmt_twos))))
      else $error("second channel word missing after fall");
   a_refill_lat: assert property (
      v2_ff |-> awake_cnt_ff == 2'h3)
      else $error("output valid before three awake falls");
   a_sleep_flush: assert property (
      fall_ev && !awake |=> !v0_ff && !v2_ff)
      else $error("pipeline not flushed on a sleeping fall");
   a_keep_convert: assert property (
      fall_ev && awake |=> v0_ff)
      else $error("awake fall did not start a conversion");
   a_mux_q_low: assert property (
      !bus_par |=> bus_q_ff == das_pkg::WORD_RST)
      else $error("second bus not low in multiplexed mode");
   a_hold_asleep: assert property (
      !hv_ff && !mv_ff |=> $stable(bus_i_ff))
      else $error("first bus changed without a valid word");

   c_par_word: cover property (rise_ev && v2_ff && bus_par ##ODA iq_sel_ff);
   c_mux_word: cover property (fall_ev && v2_ff && !bus_par ##ODA !iq_sel_ff);
   c_sleep_flush: cover property (fall_ev && !awake && v2_ff);
endmodule

// file: das_rx.sv
// Receiving logic model that captures words with the delayed channel select.
`timescale 1ns/100ps
module das_rx (
   // Clock and reset.
   input  wire logic        sys_clk_in,
   input  wire logic        rstn_in,
   // Delayed channel select and the first bus word.
   input  wire logic        iq_sel_in,
   input  wire logic [9:0]  bus_i_in,
   // Captured words of channel one and channel two.
   output logic [9:0]       ch1_word_out,
   output logic [9:0]       ch2_word_out
);
   // Previous select level, used to find its edges.
   logic sel_ff;

   ////////////////////////////////////////////////////////////////////////////
   // The word is latched on the select edges, never on a guessed clock phase.
   // That keeps the capture correct whatever output delay the device adds.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sel_ff       <= 1'b0;
         ch1_word_out <= 10'h000;
         ch2_word_out <= 10'h000;
      end else begin
         sel_ff <= iq_sel_in;
         // A rising select marks a channel one word.
         if (iq_sel_in && !sel_ff) begin
            ch1_word_out <= bus_i_in;
         end
         // A falling select marks a channel two word in multiplexed mode.
         if (!iq_sel_in && sel_ff) begin
            ch2_word_out <= bus_i_in;
         end
      end
   end
endmodule

// file: dual_adc_output_sequencer_tb.sv
// Self-checking bench of the dual converter output sequencer.
`timescale 1ns/100ps
module dual_adc_output_sequencer_tb;
   // Design stimulus and observed outputs.
   logic              sys_clk, rstn, conv_clk = 1'b0;
   logic signed [11:0] chan_i, chan_q;
   logic              bus_sel, fmt_sel, sleep, hold, trim;
   logic [9:0]        bus_i, bus_q, rx_ch1, rx_ch2;
   logic              iq_sel, trim_busy;
   // Bench counters.
   int                conv_cnt = 0, cyc_cnt = 0, err_count = 0, num_checks = 0;
   // Table of channel values for the parallel and multiplexed passes.
   int                tab_i [4] = '{100, 700, -512, 0};
   int                tab_q [4] = '{-50, -900, 511, 1};

   das_seq u_dut (.sys_clk_in(sys_clk), .rstn_in(rstn), .conv_clk_in(conv_clk),
      .chan_i_in(chan_i), .chan_q_in(chan_q), .bus_select_pin_in(bus_sel),
      .format_select_pin_in(fmt_sel), .sleep_pin_in(sleep), .low_power_hold_pin_in(hold),
      .offset_trim_pin_in(trim), .bus_i_out(bus_i), .bus_q_out(bus_q),
      .iq_sel_out(iq_sel), .trim_busy_out(trim_busy));
   das_rx u_rx (.sys_clk_in(sys_clk), .rstn_in(rstn), .iq_sel_in(iq_sel),
      .bus_i_in(bus_i), .ch1_word_out(rx_ch1), .ch2_word_out(rx_ch2));

   ////////////////////////////////////////////////////////////////////////////
   // System clock of 4 ns.
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Converter clock of ten system cycles, five high and five low, within the rate limit.
   always @(posedge sys_clk) begin
      conv_cnt <= (conv_cnt == 9) ? 0 : conv_cnt + 1;
      conv_clk <= (conv_cnt < 5);
   end
   // A hang is cut short well beyond the expected run of some 1830 cycles.
   always @(posedge sys_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000) begin
         err_count = err_count + 1;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Expected word: clamp to full scale, then invert the sign bit for offset binary.
   function automatic logic [9:0] exp_word(input int v, input logic tc);
      int         c;
      logic [9:0] w;
      c = (v > das_pkg::FS_POS) ? das_pkg::FS_POS : (v < das_pkg::FS_NEG) ? das_pkg::FS_NEG : v;
      w = c[9:0];
      return tc ? w : {~w[9], w[8:0]};
   endfunction
   // Word comparison.
   task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Flag comparison.
   task automatic chk1(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Waits, bounded, for the trim status flag to reach a level.
   task automatic wait_busy(input logic lvl, input int lim);
      int n;
      n = 0;
      while (trim_busy !== lvl && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence. Inputs change by non-blocking assignment at rising edges.
   initial begin
      rstn = 1'b0;
      chan_i = 12'sh000;
      chan_q = 12'sh000;
      {bus_sel, fmt_sel, sleep, hold, trim} = 5'b11000;
      wait_cyc(8);
      rstn <= 1'b1;
      // Parallel mode, both formats: latency, own buses and saturation.
      for (int f = 0; f < 2; f++) begin
         for (int k = 0; k < 4; k++) begin
            fmt_sel <= f[0];
            chan_i  <= 12'(tab_i[k]);
            chan_q  <= 12'(tab_q[k]);
            wait_cyc(29);
            if (k > 0) chk("old i word", exp_word(tab_i[k-1], f[0]), bus_i);
            wait_cyc(43);
            chk("par i", exp_word(tab_i[k], f[0]), bus_i);
            chk("par q", exp_word(tab_q[k], f[0]), bus_q);
         end
      end
      // Multiplexed mode: channel one at the select rise, channel two at its fall.
      bus_sel <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         chan_i <= 12'(tab_i[k]);
         chan_q <= 12'(tab_q[k]);
         wait_cyc(72);
         chk("mux ch1", exp_word(tab_i[k], 1'b1), rx_ch1);
         chk("mux ch2", exp_word(tab_q[k], 1'b1), rx_ch2);
         chk("mux q bus", 10'h000, bus_q);
      end
      // Sleep then standby: words hold, and resume only after the pipeline refills.
      bus_sel <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         chan_i <= 12'sd40;
         wait_cyc(72);
         if (p == 0) sleep <= 1'b1;
         else hold <= 1'b1;
         wait_cyc(20);
         chan_i <= -12'sd200;
         wait_cyc(72);
         chk("held word", exp_word(40, 1'b1), bus_i);
         sleep <= 1'b0;
         hold  <= 1'b0;
         wait_cyc(29);
         chk("refill word", exp_word(40, 1'b1), bus_i);
         wait_cyc(43);
         chk("woken word", exp_word(-200, 1'b1), bus_i);
      end
      // Offset trim with a constant offset on each channel.
      chan_i <= 12'sd8;
      chan_q <= -12'sd8;
      wait_cyc(72);
      chk("untrimmed", exp_word(8, 1'b1), bus_i);
      trim <= 1'b1;
      wait_busy(1'b1, 20);
      chk1("trim busy", 1'b1, trim_busy);
      wait_cyc(300);
      chk1("trim still busy", 1'b1, trim_busy);
      wait_busy(1'b0, 200);
      chk1("trim done", 1'b0, trim_busy);
      chan_i <= 12'sd20;
      wait_cyc(72);
      chk("trim i", exp_word(12, 1'b1), bus_i);
      chk("trim q", exp_word(0, 1'b1), bus_q);
      stop_test();
   end
endmodule
